/* design/event_user_routing_status.sv */
// Event user routing, channel status and interrupt enables, AHB-Lite register slave.
// Assumes channel events come from path logic on hclk and users answer on hclk.
//
// The AHB-Lite interface to the registers was left to the implementer.
`default_nettype none

module event_user_routing_status (
	// Clock and reset
	input  wire logic                                 hclk,
	input  wire logic                                 hresetn,
	// AHB-Lite slave
	input  wire logic                                 hsel,
	input  wire logic [31:0]                          haddr,
	input  wire logic [1:0]                           htrans,
	input  wire logic                                 hwrite,
	input  wire logic [2:0]                           hsize,
	input  wire logic [31:0]                          hwdata,
	input  wire logic                                 hready,
	output logic                                      hreadyout,
	output logic                                      hresp,
	output logic [31:0]                               hrdata,
	// Channels
	input  wire logic [evroute_pkg::NUM_CH-1:0]       chan_event,
	output logic [2*evroute_pkg::NUM_CH-1:0]          chan_path,
	// Event users
	input  wire logic [evroute_pkg::NUM_USERS-1:0]    user_ready,
	input  wire logic [evroute_pkg::NUM_USERS-1:0]    user_ack,
	output logic [evroute_pkg::NUM_USERS-1:0]         user_event,
	// Interrupt sources and line
	input  wire logic [evroute_pkg::NUM_CH-1:0]       evd_event,
	input  wire logic [evroute_pkg::NUM_CH-1:0]       ovr_event,
	output logic                                      irq
);
	localparam int NC = evroute_pkg::NUM_CH;
	localparam int NU = evroute_pkg::NUM_USERS;

	// ==========================================================
	// Bus slave
	logic        wr_r;
	logic [7:0]  addr_r;
	logic [31:0] hrdata_r;
	logic [31:0] rd_mux;
	logic        take;
	logic        wr_user;
	logic        wr_clr;
	logic        wr_set;
	logic        wr_sclr;
	logic        wr_path;

	// Zero wait states: every transfer completes in its first data-phase cycle
	assign take      = hsel && htrans[1] && hready;
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = hrdata_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_r    <= 1'b0;
			addr_r  <= 8'h00;
		end else begin
			wr_r    <= take && hwrite;
			addr_r  <= haddr[7:0];
		end
	end

	assign wr_user = wr_r && (addr_r == evroute_pkg::ADDR_USER);
	assign wr_clr  = wr_r && (addr_r == evroute_pkg::ADDR_INTCLR);
	assign wr_set  = wr_r && (addr_r == evroute_pkg::ADDR_INTSET);
	assign wr_sclr = wr_r && (addr_r == evroute_pkg::ADDR_IRQSCLR);
	assign wr_path = wr_r && (addr_r == evroute_pkg::ADDR_PATH);

	// ==========================================================
	// User multiplexer configuration
	logic [4:0]               user_sel_r;
	logic [4:0]               user_chan_r [NU];
	evroute_pkg::path_t       path_r      [NC];
	logic [4:0]               wr_user_code;
	logic [4:0]               wr_chan_code;
	logic [NU-1:0]            allowed;
	logic [NU-1:0]            user_event_r;

	assign wr_user_code = hwdata[evroute_pkg::POS_USER +: evroute_pkg::FIELD_W];
	assign wr_chan_code = hwdata[evroute_pkg::POS_CHAN +: evroute_pkg::FIELD_W];

	// Reserved codes and out-of-range channels are dropped rather than stored
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			user_sel_r <= 5'h00;
			for (int u = 0; u < NU; u++)
				user_chan_r[u] <= evroute_pkg::CHAN_NONE;
		end else if (wr_user && wr_user_code <= evroute_pkg::USER_LAST) begin
			user_sel_r <= wr_user_code;
			if (wr_chan_code <= evroute_pkg::CHAN_MAX)
				user_chan_r[wr_user_code] <= wr_chan_code;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int c = 0; c < NC; c++)
				path_r[c] <= evroute_pkg::PATH_SYNC;
		end else if (wr_path) begin
			for (int c = 0; c < NC; c++)
				path_r[c] <= evroute_pkg::path_t'(hwdata[2*c +: 2]);
		end
	end

	always_comb begin
		for (int c = 0; c < NC; c++)
			chan_path[2*c +: 2] = path_r[c];
	end

	genvar gu;
	generate
		for (gu = 0; gu < NU; gu++) begin : g_user
			evroute_pkg::path_t upath;
			assign upath = (user_chan_r[gu] == evroute_pkg::CHAN_NONE) ?
				evroute_pkg::PATH_SYNC : path_r[4'(user_chan_r[gu] - 5'h01)];
			user_path_check #(.CODE(5'(gu))) u_check (
				.path    (upath),
				.allowed (allowed[gu])
			);
		end
	endgenerate

	// ==========================================================
	// Channel trackers
	chan_link_if     link [NC] ();
	logic [NC-1:0]   busy;
	logic [NC-1:0]   chan_ready;
	logic [NU-1:0]   attached [NC];

	always_comb begin
		for (int c = 0; c < NC; c++)
			for (int u = 0; u < NU; u++)
				attached[c][u] = allowed[u] && (user_chan_r[u] == 5'(c + 1));
	end

	genvar gc;
	generate
		for (gc = 0; gc < NC; gc++) begin : g_chan
			assign link[gc].event_in   = chan_event[gc];
			assign link[gc].attached   = attached[gc];
			assign link[gc].ack        = user_ack;
			assign link[gc].user_ready = user_ready;
			assign busy[gc]            = link[gc].busy;
			assign chan_ready[gc]      = link[gc].ready;
			chan_tracker u_trk (
				.hclk    (hclk),
				.hresetn (hresetn),
				.link    (link[gc])
			);
		end
	endgenerate

	// Forward each channel event to the users attached to it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			user_event_r <= '0;
		end else begin
			for (int u = 0; u < NU; u++) begin
				user_event_r[u] <= 1'b0;
				for (int c = 0; c < NC; c++)
					if (attached[c][u] && chan_event[c])
						user_event_r[u] <= 1'b1;
			end
		end
	end
	assign user_event = user_event_r;

	// ==========================================================
	// Interrupt enables and sticky status
	logic [31:0] en_r;
	logic [31:0] en_nxt;
	logic [31:0] st_r;
	logic [31:0] st_set;

	always_comb begin
		en_nxt = en_r;
		if (wr_set)
			en_nxt = en_nxt | (hwdata & evroute_pkg::VALID_MASK);
		if (wr_clr)
			en_nxt = en_nxt & ~(hwdata & evroute_pkg::VALID_MASK);
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			en_r <= evroute_pkg::RST_INTEN;
		else
			en_r <= en_nxt;
	end

	assign st_set = evroute_pkg::spread(evd_event, 1'b1) | evroute_pkg::spread(ovr_event, 1'b0);

	// Set beats clear so an event landing on the clear write is kept
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			st_r <= 32'h0000_0000;
		else if (wr_sclr)
			st_r <= (st_r & ~hwdata) | st_set;
		else
			st_r <= st_r | st_set;
	end

	assign irq = |(st_r & en_r);

	// ==========================================================
	// Read path
	logic [31:0] chstat;
	assign chstat = evroute_pkg::spread(busy, 1'b1) | evroute_pkg::spread(chan_ready, 1'b0);

	// Reads are sampled in the address phase, so a read whose address phase overlaps
	// a write's data phase returns the value from before that write
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (haddr[7:0])
			evroute_pkg::ADDR_USER: begin
				rd_mux[evroute_pkg::POS_USER +: evroute_pkg::FIELD_W] = user_sel_r;
				rd_mux[evroute_pkg::POS_CHAN +: evroute_pkg::FIELD_W] = user_chan_r[user_sel_r];
			end
			evroute_pkg::ADDR_CHSTAT:  rd_mux = chstat;
			evroute_pkg::ADDR_INTCLR:  rd_mux = en_r;
			evroute_pkg::ADDR_INTSET:  rd_mux = en_r;
			evroute_pkg::ADDR_IRQSTAT: rd_mux = st_r;
			evroute_pkg::ADDR_PATH: begin
				for (int c = 0; c < NC; c++)
					rd_mux[2*c +: 2] = path_r[c];
			end
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			hrdata_r <= 32'h0000_0000;
		else if (take && !hwrite)
			hrdata_r <= rd_mux;
	end

	// ==========================================================
	// Checks
	AST_USER_RDY_DROP: assert property (@(posedge hclk) disable iff (!hresetn)
		((attached[3] & ~user_ready) != '0) |-> !chstat[evroute_pkg::POS_RDY_LO + 3])
		else $error("channel 3 ready while an attached user is not");
	AST_RDY_ALL: assert property (@(posedge hclk) disable iff (!hresetn)
		((attached[9] & ~user_ready) == '0) |-> chstat[evroute_pkg::POS_RDY_HI + 1])
		else $error("channel 9 not ready though all users are");
	AST_CLR_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_clr && hwdata[evroute_pkg::POS_BUSY_HI] |=> !en_r[evroute_pkg::POS_BUSY_HI])
		else $error("event-detected enable of channel 8 not cleared");
	AST_CLR_OVR: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_clr && hwdata[evroute_pkg::POS_RDY_LO] |=> !en_r[evroute_pkg::POS_RDY_LO])
		else $error("overrun enable of channel 0 not cleared");
	AST_ZERO_KEEP: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_clr && !wr_set |=> ((en_r & ~$past(hwdata)) == ($past(en_r) & ~$past(hwdata))))
		else $error("zero bits of a clear write changed an enable");
	AST_SET_SHARED: assert property (@(posedge hclk) disable iff (!hresetn)
		wr_set && !wr_clr |=> ((en_r & $past(hwdata) & evroute_pkg::VALID_MASK)
			== ($past(hwdata) & evroute_pkg::VALID_MASK)))
		else $error("set enable not held in the shared enable state");
	AST_SET_READ: assert property (@(posedge hclk) disable iff (!hresetn)
		take && !hwrite && haddr[7:0] == evroute_pkg::ADDR_INTSET |=> hrdata == $past(en_r))
		else $error("set register read differs from enable state");
	AST_CLR_READ: assert property (@(posedge hclk) disable iff (!hresetn)
		take && !hwrite && haddr[7:0] == evroute_pkg::ADDR_INTCLR |=> hrdata == $past(en_r))
		else $error("clear register read differs from enable state");
	AST_RESERVED_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
		(en_r & ~evroute_pkg::VALID_MASK) == '0 && (chstat & ~evroute_pkg::VALID_MASK) == '0)
		else $error("unused bit reads as one");
	AST_ASYNC_ONLY: assert property (@(posedge hclk) disable iff (!hresetn)
		allowed[evroute_pkg::USER_ASYNC_FIRST] && user_chan_r[evroute_pkg::USER_ASYNC_FIRST] != '0
		|-> path_r[4'(user_chan_r[evroute_pkg::USER_ASYNC_FIRST] - 5'h01)] == evroute_pkg::PATH_ASYNC)
		else $error("converter start attached over a non-async path");
	AST_TOUCH_ASYNC: assert property (@(posedge hclk) disable iff (!hresetn)
		allowed[evroute_pkg::USER_TOUCH] && user_chan_r[evroute_pkg::USER_TOUCH] != '0
		|-> path_r[4'(user_chan_r[evroute_pkg::USER_TOUCH] - 5'h01)] == evroute_pkg::PATH_ASYNC)
		else $error("touch start attached over a non-async path");
	AST_ANY_PATH: assert property (@(posedge hclk) disable iff (!hresetn)
		user_chan_r[evroute_pkg::USER_ANY_LAST] != evroute_pkg::CHAN_NONE
		|-> attached[4'(user_chan_r[evroute_pkg::USER_ANY_LAST] - 5'h01)]
			[evroute_pkg::USER_ANY_LAST])
		else $error("timer user refused by its channel");
	AST_BUSY_REG: assert property (@(posedge hclk) disable iff (!hresetn)
		!busy[11] |-> !chstat[evroute_pkg::POS_BUSY_HI + 3])
		else $error("channel 11 busy shown while idle");
	// An event reaches an attached user and marks its channel busy on the same edge
	AST_EVENT_FWD: assert property (@(posedge hclk) disable iff (!hresetn)
		chan_event[NC-1] && attached[NC-1][evroute_pkg::USER_ANY_LAST]
		|=> user_event[evroute_pkg::USER_ANY_LAST] && busy[NC-1])
		else $error("event on channel 11 not forwarded or not marked busy");
	// Detaching the last user must not leave a channel stuck busy
	AST_DETACH_IDLE: assert property (@(posedge hclk) disable iff (!hresetn)
		attached[1] == '0 |=> !busy[1])
		else $error("channel 1 busy with no users attached");
endmodule

`default_nettype wire

/* pkg/evroute_pkg.sv */
// Constants, field layouts and types for the event user routing and status block.
// Assumes one 250 MHz bus clock and a single AHB-Lite slave port on the register side.
`default_nettype none

package evroute_pkg;
	localparam int          NUM_CH      = 12;
	localparam int          NUM_USERS   = 29;
	localparam int          LO_N        = 8;
	localparam int          HI_N        = 4;
	// Register byte offsets
	localparam logic [7:0]  ADDR_USER    = 8'h08;
	localparam logic [7:0]  ADDR_CHSTAT  = 8'h0C;
	localparam logic [7:0]  ADDR_INTCLR  = 8'h10;
	localparam logic [7:0]  ADDR_INTSET  = 8'h14;
	localparam logic [7:0]  ADDR_IRQSTAT = 8'h18;
	localparam logic [7:0]  ADDR_IRQSCLR = 8'h1C;
	localparam logic [7:0]  ADDR_PATH    = 8'h20;
	// Field positions: ready/overrun in the low halves, busy/event-detected above
	localparam int          POS_RDY_LO  = 0;
	localparam int          POS_BUSY_LO = 8;
	localparam int          POS_RDY_HI  = 16;
	localparam int          POS_BUSY_HI = 24;
	localparam int          POS_USER    = 0;
	localparam int          POS_CHAN    = 8;
	localparam int          FIELD_W     = 5;
	localparam logic [31:0] VALID_MASK  = 32'h0F0F_FFFF;
	localparam logic [31:0] RST_CHSTAT  = 32'h000F_00FF;
	localparam logic [31:0] RST_INTEN   = 32'h0000_0000;
	localparam logic [4:0]  CHAN_NONE   = 5'h00;
	localparam logic [4:0]  CHAN_MAX    = 5'h0C;
	// User selector codes
	localparam logic [4:0]  USER_ANY_FIRST   = 5'h04;
	localparam logic [4:0]  USER_ANY_LAST    = 5'h16;
	localparam logic [4:0]  USER_ASYNC_FIRST = 5'h17;
	localparam logic [4:0]  USER_ASYNC_LAST  = 5'h1A;
	localparam logic [4:0]  USER_DAC         = 5'h1B;
	localparam logic [4:0]  USER_TOUCH       = 5'h1C;
	localparam logic [4:0]  USER_LAST        = 5'h1C;

	typedef enum logic [1:0] {
		PATH_SYNC   = 2'h0,
		PATH_RESYNC = 2'h1,
		PATH_ASYNC  = 2'h2
	} path_t;

	// Spread a 12-bit per-channel vector into its split register layout
	function automatic logic [31:0] spread(input logic [11:0] v, input logic upper);
		logic [31:0] r;
		r = 32'h0000_0000;
		if (upper) begin
			r[POS_BUSY_LO +: LO_N] = v[LO_N-1:0];
			r[POS_BUSY_HI +: HI_N] = v[NUM_CH-1:LO_N];
		end else begin
			r[POS_RDY_LO +: LO_N] = v[LO_N-1:0];
			r[POS_RDY_HI +: HI_N] = v[NUM_CH-1:LO_N];
		end
		return r;
	endfunction
endpackage

`default_nettype wire

/* pkg/chan_link_if.sv */
// Per-channel bundle between the router core and one channel tracker.
// Assumes both ends run on the same bus clock.
`default_nettype none

interface chan_link_if;
	logic                                 event_in;
	logic [evroute_pkg::NUM_USERS-1:0]    attached;
	logic [evroute_pkg::NUM_USERS-1:0]    ack;
	logic [evroute_pkg::NUM_USERS-1:0]    user_ready;
	logic                                 busy;
	logic                                 ready;
	logic [evroute_pkg::NUM_USERS-1:0]    pending;

	modport tracker (input event_in, attached, ack, user_ready, output busy, ready, pending);
	modport core    (output event_in, attached, ack, user_ready, input busy, ready, pending);
endinterface

`default_nettype wire

/* design/user_path_check.sv */
// Decides whether one event user may take the path type of its channel.
// Assumes a constant user code per instance.
`default_nettype none

module user_path_check #(
	parameter logic [4:0] CODE = 5'h00
) (
	// Path of the channel the user points at
	input  wire evroute_pkg::path_t path,
	// Verdict
	output logic                    allowed
);
	always_comb begin
		if (CODE < evroute_pkg::USER_ANY_FIRST)
			allowed = (path == evroute_pkg::PATH_RESYNC);
		else if (CODE <= evroute_pkg::USER_ANY_LAST)
			allowed = 1'b1;
		else if (CODE <= evroute_pkg::USER_ASYNC_LAST)
			allowed = (path == evroute_pkg::PATH_ASYNC);
		else if (CODE == evroute_pkg::USER_DAC)
			allowed = 1'b1;
		else if (CODE == evroute_pkg::USER_TOUCH)
			allowed = (path == evroute_pkg::PATH_ASYNC);
		else
			allowed = 1'b0;
	end
endmodule

`default_nettype wire

/* design/chan_tracker.sv */
// Tracks which attached users still owe an acknowledge for the last channel event.
// Assumes event and acknowledge pulses are on the bus clock.
`default_nettype none

module chan_tracker (
	// Clock and reset
	input  wire logic         hclk,
	input  wire logic         hresetn,
	// Channel bundle
	chan_link_if.tracker      link
);
	logic [evroute_pkg::NUM_USERS-1:0] pending_r;
	logic [evroute_pkg::NUM_USERS-1:0] pending_nxt;

	// A new event re-arms every attached user; an ack in the same cycle is for the old one
	always_comb begin
		pending_nxt = pending_r & ~link.ack & link.attached;
		if (link.event_in)
			pending_nxt = link.attached;
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			pending_r <= '0;
		else
			pending_r <= pending_nxt;
	end

	assign link.busy    = |pending_r;
	assign link.pending = pending_r;
	// No attached user counts as ready, matching the reset view
	assign link.ready   = &(link.user_ready | ~link.attached);

	AST_BUSY_SET: assert property (@(posedge hclk) disable iff (!hresetn)
		link.event_in && (|link.attached) ##1 (|link.attached) |-> link.busy)
		else $error("busy not set after event on channel with users");
	AST_IDLE_CLEAR: assert property (@(posedge hclk) disable iff (!hresetn)
		link.busy && !link.event_in && ((pending_r & ~link.ack) == '0) |=> !link.busy)
		else $error("busy still set after all users handled the event");
endmodule

`default_nettype wire

/* tb/event_users_model.sv */
// Behavioural event users: each takes a routed event, stays busy, then acknowledges.
// Assumes user_event pulses for one hclk cycle and hold comes from the bench.
`default_nettype none

module event_users_model (
	// Clock and reset
	input  wire logic        hclk,
	input  wire logic        hresetn,
	// Bench control: answer delay in cycles, users kept not ready
	input  wire logic [7:0]  delay,
	input  wire logic [28:0] hold,
	// Event user side
	input  wire logic [28:0] user_event,
	output logic [28:0]      user_ready,
	output logic [28:0]      user_ack
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [28:0] pend_r;
	logic [7:0]  cnt_r [29];

	// A user is never ready while it still owes an acknowledge
	assign user_ready = ~pend_r & ~hold;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pend_r <= 29'h0;
			user_ack <= 29'h0;
			for (int i = 0; i < 29; i++) begin
				cnt_r[i] <= 8'h00;
			end
		end else begin
			for (int i = 0; i < 29; i++) begin
				user_ack[i] <= 1'b0;
				if (user_event[i]) begin
					pend_r[i] <= 1'b1;
					cnt_r[i] <= delay;
				end else if (pend_r[i] && cnt_r[i] == 8'h00) begin
					pend_r[i] <= 1'b0;
					user_ack[i] <= 1'b1;
				end else if (pend_r[i]) begin
					cnt_r[i] <= cnt_r[i] - 8'h01;
				end
			end
		end
	end
endmodule

`default_nettype wire

/* tb/event_user_routing_status_bench.sv */
// Self-checking bench: AHB-Lite master tasks, event pulses, behavioural users.
// Assumes a zero-wait-state slave; every wait is bounded.
`default_nettype none

module event_user_routing_status_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	logic [11:0] chan_event, evd_event, ovr_event;
	logic [23:0] chan_path;
	logic [28:0] user_ready, user_ack, user_event, hold;
	logic [7:0]  delay;
	int          num_errors, n_checks;

	event_user_routing_status uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .chan_event(chan_event),
		.chan_path(chan_path), .user_ready(user_ready), .user_ack(user_ack),
		.user_event(user_event), .evd_event(evd_event), .ovr_event(ovr_event), .irq(irq));

	event_users_model users (.hclk(hclk), .hresetn(hresetn), .delay(delay), .hold(hold),
		.user_event(user_event), .user_ready(user_ready), .user_ack(user_ack));

	always #2 hclk = ~hclk;

	// ==========================================
	// Shared tasks
	task automatic finish_test();
		$display("checks %0d mismatches %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			$display("ERROR %s expected %h seen %h", what, exp, got);
			num_errors++;
		end
	endtask

	task automatic wait_rdy();
		int i;
		i = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			i++;
			if (i > 50) begin
				chk("hreadyout", 32'h1, {31'h0, hreadyout});
				finish_test();
			end
			@(posedge hclk);
		end
	endtask

	// Address phase held until hready, then data phase held until hready again
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
		rd = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
		#1;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string what);
		bus(a, 1'b0, 32'h0);
		chk(what, exp, rd);
	endtask

	task automatic pulse(input logic [11:0] ce, input logic [11:0] ev, input logic [11:0] ov);
		@(posedge hclk);
		chan_event <= ce;
		evd_event <= ev;
		ovr_event <= ov;
		@(posedge hclk);
		chan_event <= 12'h000;
		evd_event <= 12'h000;
		ovr_event <= 12'h000;
		#1;
	endtask

	task automatic wait_idle();
		int i;
		for (i = 0; i < 100; i++) begin
			bus(evroute_pkg::ADDR_CHSTAT, 1'b0, 32'h0);
			if ((rd & 32'h0F00_FF00) === 32'h0) break;
		end
		chk("channel_status idle", evroute_pkg::RST_CHSTAT, rd);
		if (i == 100) finish_test();
	endtask

	// ==========================================
	// Scenarios
	task automatic t_reset();
		rdc(evroute_pkg::ADDR_CHSTAT, evroute_pkg::RST_CHSTAT, "channel_status");
		rdc(evroute_pkg::ADDR_INTCLR, evroute_pkg::RST_INTEN, "enable_clear");
		wr(evroute_pkg::ADDR_CHSTAT, 32'hFFFF_FFFF);
		rdc(evroute_pkg::ADDR_CHSTAT, evroute_pkg::RST_CHSTAT, "status written");
		rdc(8'h40, 32'h0, "unmapped");
		$display("test reset done");
	endtask

	// Users 0x07 on channel 0 and 0x16 on channel 11, every path type, slow acks
	task automatic t_timer();
		logic [31:0] p;
		delay <= 8'h1E;
		wr(evroute_pkg::ADDR_USER, 32'h0000_0107);
		wr(evroute_pkg::ADDR_USER, 32'h0000_0C16);
		for (int k = 0; k < 3; k++) begin
			p = 32'(k);
			wr(evroute_pkg::ADDR_PATH, p | (p << 22));
			chk("chan_path", p | (p << 22), {8'h0, chan_path});
			pulse(12'h801, 12'h000, 12'h000);
			chk("user_event timers", 32'h0040_0080, {3'h0, user_event});
			rdc(evroute_pkg::ADDR_CHSTAT, 32'h0807_01FE, "status busy");
			wait_idle();
		end
		$display("test timer paths done");
	endtask

	task automatic t_async();
		logic [4:0] codes [5];
		codes = '{5'h17, 5'h18, 5'h19, 5'h1A, 5'h1C};
		delay <= 8'h00;
		wr(evroute_pkg::ADDR_PATH, 32'h0);
		foreach (codes[j]) begin
			wr(evroute_pkg::ADDR_USER, {19'h0, 5'h02, 3'h0, codes[j]});
			pulse(12'h002, 12'h000, 12'h000);
			chk("user_event sync path", 32'h0, {3'h0, user_event});
			wr(evroute_pkg::ADDR_PATH, 32'h0000_0008);
			pulse(12'h002, 12'h000, 12'h000);
			chk("user_event async path", 32'h1 << codes[j], {3'h0, user_event});
			wait_idle();
			wr(evroute_pkg::ADDR_USER, {27'h0, codes[j]});
			wr(evroute_pkg::ADDR_PATH, 32'h0);
		end
		// Reserved user code: the whole write is dropped
		wr(evroute_pkg::ADDR_USER, 32'h0000_041D);
		rdc(evroute_pkg::ADDR_USER, 32'h0000_001C, "user reserved");
		$display("test async users done");
	endtask

	task automatic t_ready();
		wr(evroute_pkg::ADDR_USER, 32'h0000_0404);
		wr(evroute_pkg::ADDR_USER, 32'h0000_0405);
		hold <= 29'h0000_0020;
		rdc(evroute_pkg::ADDR_CHSTAT, 32'h000F_00F7, "one user held");
		hold <= 29'h0;
		rdc(evroute_pkg::ADDR_CHSTAT, evroute_pkg::RST_CHSTAT, "all users ready");
		$display("test user ready done");
	endtask

	task automatic t_enables();
		wr(evroute_pkg::ADDR_INTSET, 32'hFFFF_FFFF);
		rdc(evroute_pkg::ADDR_INTCLR, evroute_pkg::VALID_MASK, "enables set");
		wr(evroute_pkg::ADDR_INTCLR, 32'h0000_0100);
		rdc(evroute_pkg::ADDR_INTCLR, 32'h0F0F_FEFF, "detect cleared");
		wr(evroute_pkg::ADDR_INTCLR, 32'h0001_0000);
		rdc(evroute_pkg::ADDR_INTSET, 32'h0F0E_FEFF, "overrun cleared");
		wr(evroute_pkg::ADDR_INTCLR, 32'h0);
		rdc(evroute_pkg::ADDR_INTCLR, 32'h0F0E_FEFF, "zero write");
		pulse(12'h000, 12'h004, 12'h000);
		chk("irq detect", 32'h1, {31'h0, irq});
		wr(evroute_pkg::ADDR_INTCLR, 32'h0000_0400);
		chk("irq detect disabled", 32'h0, {31'h0, irq});
		pulse(12'h000, 12'h000, 12'h001);
		chk("irq overrun", 32'h1, {31'h0, irq});
		wr(evroute_pkg::ADDR_INTCLR, 32'h0000_0001);
		chk("irq overrun disabled", 32'h0, {31'h0, irq});
		wr(evroute_pkg::ADDR_IRQSCLR, 32'hFFFF_FFFF);
		wr(evroute_pkg::ADDR_INTCLR, 32'hFFFF_FFFF);
		rdc(evroute_pkg::ADDR_INTCLR, 32'h0, "all cleared");
		$display("test interrupt enables done");
	endtask

	// ==========================================
	// Main sequence
	initial begin
		hclk = 1'b0;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		chan_event = 12'h000;
		evd_event = 12'h000;
		ovr_event = 12'h000;
		hold = 29'h0;
		delay = 8'h00;
		num_errors = 0;
		n_checks = 0;
		repeat (12) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_timer();
		t_async();
		t_ready();
		t_enables();
		finish_test();
	end
endmodule

`default_nettype wire
